//--- tb/acdr_host_model.sv
// Host side of the serial link: frames commands, write data and readback.
// Assumes the device samples on sclk rise and shifts its pin on sclk fall.
`timescale 1ns/1ps
module acdr_host_model (
   // Link pins
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      mosi_out,
   input  wire logic miso_in
);
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      mosi_out = 1'b0;
   end
   // Clock runs only inside a frame; data bits follow the command byte
   task automatic frame(input logic [7:0] cmd, input logic [23:0] wd,
                        input int n, output logic [23:0] rd);
      logic [31:0] sh;
      sh = {cmd, wd};
      rd = 24'h0;
      cs_n_out = 1'b0;
      for (int i = 0; i < 8 + n; i++) begin
         mosi_out = sh[31 - i];
         #80 sclk_out = 1'b1;
         if (i >= 8) rd = {rd[22:0], miso_in};
         #80 sclk_out = 1'b0;
      end
      #80 cs_n_out = 1'b1;
      // Released line shows no stale level
      mosi_out = ~mosi_out;
   endtask
endmodule

//--- tb/test_acdr_top.sv
// Bench of the converter registers: link accesses and conversions.
// Assumes the host model frames all accesses; samples are fed here.
`timescale 1ns/1ps
module test_acdr_top;
   import acdr_pkg::*;
   logic        clk, rst_n, sclk, cs_n, mosi, rdy, raw_v, start, stop;
   logic        line_sel, uni, clk_src, ref_en, sig_en, run, pdn, ovr, und, oe_n;
   logic [3:0]  gpio_in, gpio_out, gpio_oe_n;
   logic [23:0] raw, offs, gain, rd, keep;
   int          mismatches = 0;
   int          check_count = 0;
   int          cycles = 0;

   acdr_host_model host (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(rdy));
   acdr_top dut (
      .core_clk_in(clk), .reset_n_in(rst_n), .sclk_in(sclk), .chip_select_n_in(cs_n),
      .serial_data_in(mosi), .rdy_dout_out(rdy), .rdy_dout_oe_n_out(oe_n),
      .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n_out(gpio_oe_n),
      .raw_sample_in(raw), .raw_valid_in(raw_v), .conv_start_in(start),
      .conv_stop_in(stop), .self_offset_coef_in(offs), .self_gain_coef_in(gain),
      .sys_offset_coef_in(offs), .sys_gain_coef_in(gain),
      .line_frequency_select_out(line_sel), .unipolar_select_out(uni),
      .clock_source_select_out(clk_src), .reference_buffer_enable_out(ref_en),
      .signal_buffer_enable_out(sig_en), .modulator_run_out(run),
      .power_down_out(pdn), .overrange_out(ovr), .underrange_out(und));

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Settle time after a frame covers the write crossing into core
   task automatic wr(input logic [3:0] sel, input logic [7:0] v);
      host.frame({3'b110, sel, 1'b0}, {v, 16'h0}, 8, rd);
      repeat (10) @(posedge clk);
      #5;
   endtask
   task automatic rdr(input logic [3:0] sel, input int n);
      host.frame({3'b110, sel, 1'b1}, 24'h0, n, rd);
      repeat (10) @(posedge clk);
      #5;
   endtask
   task automatic go();
      @(posedge clk);
      #5 start = 1'b1;
      @(posedge clk);
      #5 start = 1'b0;
   endtask
   task automatic conv(input logic [23:0] r);
      @(posedge clk);
      #5 raw = r;
      raw_v = 1'b1;
      @(posedge clk);
      #5 raw_v = 1'b0;
      repeat (4) @(posedge clk);
      #5;
   endtask
   // One single-cycle conversion, then the result read over the link
   task automatic tconv(input logic [7:0] c1, input logic [7:0] c3,
                        input logic [23:0] r, input logic [17:0] e);
      wr(4'h1, c1);
      wr(4'h3, c3);
      go();
      check({23'h0, run}, 24'h1);
      conv(r);
      check({22'h0, pdn, rdy}, 24'h3);
      rdr(4'h4, 24);
      check(rd, {e, 6'h0});
      check({23'h0, rdy}, 24'h0);
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Generous ceiling: the whole sequence needs under 10000 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         give_verdict();
      end
   end

   initial begin
      rst_n = 1'b0;
      gpio_in = 4'h9;
      raw = 24'h0;
      raw_v = 1'b0;
      start = 1'b0;
      stop = 1'b0;
      offs = 24'h002000;
      gain = 24'h400000;
      repeat (20) @(posedge clk);
      #5 rst_n = 1'b1;
      check({16'h0, gpio_oe_n, gpio_out}, 24'hff);
      check({23'h0, oe_n}, 24'h1);
      rdr(4'h1, 8);
      check(rd, 24'h02);
      rdr(4'h3, 8);
      check(rd, 24'h1e);
      rdr(4'h2, 8);
      check(rd, 24'h09);
      for (int i = 0; i < 5; i++) begin
         wr(4'h1, 8'h80 >> i);
         check({19'h0, line_sel, uni, clk_src, ref_en, sig_en}, 24'h10 >> i);
         rdr(4'h1, 8);
         check(rd, 24'h80 >> i);
      end
      wr(4'h2, 8'ha5);
      check({16'h0, gpio_oe_n, gpio_out}, 24'h55);
      gpio_in = 4'h6;
      rdr(4'h2, 8);
      check(rd, 24'ha4);
      tconv(8'h42, 8'h1e, 24'h400000, 18'h20000);
      tconv(8'h42, 8'h1e, 24'h7fffff, 18'h3ffff);
      tconv(8'h42, 8'h1e, 24'hfff000, 18'h00000);
      check({23'h0, und}, 24'h1);
      tconv(8'h02, 8'h1e, 24'h800000, 18'h20000);
      tconv(8'h02, 8'h1e, 24'h7fffff, 18'h1ffff);
      tconv(8'h42, 8'h3e, 24'h7fffff, 18'h3ffff);
      check({23'h0, ovr}, 24'h1);
      tconv(8'h02, 8'h3e, 24'h800000, 18'h20000);
      check({23'h0, und}, 24'h1);
      tconv(8'h06, 8'h1e, 24'h000000, 18'h20000);
      tconv(8'h46, 8'h1e, 24'h400000, 18'h20000);
      tconv(8'h02, 8'h3e, 24'h200000, 18'h10000);
      tconv(8'h02, 8'hfe, 24'h000040, 18'h00080);
      tconv(8'h02, 8'hfe, 24'h200000, 18'h1ffff);
      check({23'h0, ovr}, 24'h1);
      tconv(8'h02, 8'h1c, 24'h004000, 18'h00080);
      tconv(8'h02, 8'h18, 24'h004000, 18'h00040);
      tconv(8'h02, 8'h16, 24'h004000, 18'h00080);
      tconv(8'h02, 8'h06, 24'h004000, 18'h00040);
      tconv(8'h02, 8'h1e, 24'h004000, 18'h00100);
      keep = rd;
      wr(4'h4, 8'h55);
      rdr(4'h4, 24);
      check(rd, keep);
      wr(4'h1, 8'h00);
      go();
      for (int i = 0; i < 3; i++) conv(24'h7fffff);
      check({23'h0, rdy}, 24'h0);
      conv(24'h004000);
      check({22'h0, rdy, run}, 24'h3);
      rdr(4'h4, 24);
      check(rd, 24'h004000);
      @(posedge clk);
      #5 stop = 1'b1;
      @(posedge clk);
      #5 stop = 1'b0;
      @(posedge clk);
      #5 check({23'h0, pdn}, 24'h1);
      give_verdict();
   end
endmodule

//--- verilog/acdr_corr_if.sv
// Carrier between register logic and the result corrector.
// Assumes both ends sit on the core clock.
`timescale 1ns/1ps
interface acdr_corr_if;
   logic [23:0] raw;
   logic        raw_valid;
   logic [3:0]  skip;
   logic [2:0]  gain;
   logic        uni;
   logic        fmt;
   logic [23:0] scoc;
   logic [23:0] scgc;
   logic [23:0] soc;
   logic [23:0] sgc;
   logic [17:0] code;
   logic        code_valid;
   logic        over;
   logic        under;
   modport ctl (output raw, raw_valid, skip, gain, uni, fmt, scoc, scgc, soc, sgc,
                input code, code_valid, over, under);
   modport dp  (input raw, raw_valid, skip, gain, uni, fmt, scoc, scgc, soc, sgc,
                output code, code_valid, over, under);
endinterface

//--- verilog/acdr_corrector.sv
// Calibration, digital gain, scaling, clipping and output coding of one sample.
// Assumes a signed 24-bit filter output; gain coefficients are 1.23 unsigned.
`timescale 1ns/1ps
module acdr_corrector
   import acdr_pkg::*;
(
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   // Datapath side
   acdr_corr_if.dp   c
);
   function automatic logic signed [55:0] sext(input logic [23:0] v);
      return {{32{v[23]}}, v};
   endfunction

   logic signed [55:0] s1, s2, s3, s4, s5, q, hi, lo;
   logic               ov, un;
   logic [17:0]        code_next;

   // Single combinational pass; one register stage keeps the result timing fixed
   always_comb begin
      s1 = sext(c.raw);
      if (!c.skip[0]) s1 = s1 - sext(c.scoc);
      s2 = c.skip[1] ? s1 : (s1 * $signed({32'h0, c.scgc})) >>> GAIN_FRAC;
      s3 = c.skip[2] ? s2 : s2 - sext(c.soc);
      s4 = c.skip[3] ? s3 : (s3 * $signed({32'h0, c.sgc})) >>> GAIN_FRAC;
      s5 = s4 <<< c.gain;
      q  = c.uni ? (s5 >>> SH_UNI) : (s5 >>> SH_BIP);
      hi = c.uni ? UNI_HI : BIP_HI;
      lo = c.uni ? UNI_LO : BIP_LO;
      ov = q > hi;
      un = q < lo;
      code_next = ov ? hi[17:0] : (un ? lo[17:0] : q[17:0]);
      if (!c.uni && c.fmt) code_next[17] = ~code_next[17];
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         c.code       <= 18'h0;
         c.code_valid <= 1'b0;
         c.over       <= 1'b0;
         c.under      <= 1'b0;
      end else begin
         c.code_valid <= c.raw_valid;
         if (c.raw_valid) begin
            c.code  <= code_next;
            c.over  <= ov;
            c.under <= un;
         end
      end
   end

   AST_UNI_CLIP:
   assert property (@(posedge clk_in) disable iff (!rst_n_in)
      c.raw_valid && c.uni && ov |=> c.code == 18'h3ffff && c.over)
   else $error("unipolar overrange not clipped to top code");

   AST_BIP_LOW:
   assert property (@(posedge clk_in) disable iff (!rst_n_in)
      c.raw_valid && !c.uni && !c.fmt && un |=> c.code == 18'h20000 && c.under)
   else $error("bipolar underrange not clipped to negative full scale");

   AST_OFFSET_BIN:
   assert property (@(posedge clk_in) disable iff (!rst_n_in)
      c.raw_valid && !c.uni && c.fmt && !ov && !un |=> c.code[17] != $past(q[17]))
   else $error("offset binary sign bit not inverted");

   AST_PASS_THRU:
   assert property (@(posedge clk_in) disable iff (!rst_n_in)
      c.raw_valid && c.skip == 4'hf && c.gain == 3'h0 && !c.uni && !c.fmt
      |=> c.code == $past(c.raw[23:6]))
   else $error("disabled corrections still alter the result");
endmodule

//--- verilog/acdr_pkg.sv
// Shared constants and types of the converter control and result registers.
// Assumes a byte-wide register map reached over a four-wire serial link.
package acdr_pkg;
   localparam logic [3:0]  RS_CONV_CTL = 4'h1;
   localparam logic [3:0]  RS_PIN_CTL  = 4'h2;
   localparam logic [3:0]  RS_CAL_CTL  = 4'h3;
   localparam logic [3:0]  RS_DATA     = 4'h4;
   localparam logic [7:0]  CONV_CTL_RST  = 8'h02;
   localparam logic [7:0]  PIN_CTL_RST   = 8'h0f;
   localparam logic [7:0]  CAL_CTL_RST   = 8'h1e;
   localparam logic [7:0]  CONV_CTL_MASK = 8'hfe;
   localparam logic [7:0]  CAL_CTL_MASK  = 8'hfe;
   localparam int B_LINE_FREQ = 7, B_UNI = 6, B_CLK_SRC = 5, B_REF_BUF = 4;
   localparam int B_SIG_BUF = 3, B_FORMAT = 2, B_SINGLE = 1;
   localparam int B_GAIN = 5, B_SYS_GAIN_OFF = 4, B_SYS_OFS_OFF = 3;
   localparam int B_SELF_GAIN_OFF = 2, B_SELF_OFS_OFF = 1;
   localparam int B_DIR = 4;
   localparam int B_START = 7, B_MODE = 6, B_RS = 1, B_READ = 0;
   localparam logic [5:0]  CNT_CMD_LAST  = 6'h07;
   localparam logic [5:0]  CNT_CMD       = 6'h08;
   localparam logic [5:0]  CNT_BYTE_LAST = 6'h0f;
   localparam logic [5:0]  CNT_WORD_LAST = 6'h1f;
   localparam logic [5:0]  CNT_MAX       = 6'h3f;
   localparam logic [1:0]  DISCARD_LAST  = 2'h2;
   localparam int GAIN_FRAC = 23;
   localparam int SH_UNI = 5, SH_BIP = 6;
   localparam logic signed [55:0] UNI_HI = 56'sh3ffff;
   localparam logic signed [55:0] UNI_LO = 56'sh0;
   localparam logic signed [55:0] BIP_HI = 56'sh1ffff;
   localparam logic signed [55:0] BIP_LO = -56'sh20000;
   typedef enum logic [1:0] {CV_OFF, CV_SETTLE, CV_RUN} acdr_conv_t;
endpackage

//--- verilog/acdr_top.sv
// Control, pin and result registers of a delta-sigma converter behind a serial link.
// Assumes the link clock idles between frames; the filter delivers samples on core clock.
`timescale 1ns/1ps
module acdr_top
   import acdr_pkg::*;
#(
   parameter int GPIO_N = 4
) (
   // Core clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        reset_n_in,
   // Serial link
   input  wire logic        sclk_in,
   input  wire logic        chip_select_n_in,
   input  wire logic        serial_data_in,
   output logic             rdy_dout_out,
   output logic             rdy_dout_oe_n_out,
   // General pins
   input  wire logic [3:0]  gpio_in,
   output logic [3:0]       gpio_out,
   output logic [3:0]       gpio_oe_n_out,
   // Filter samples and conversion requests
   input  wire logic [23:0] raw_sample_in,
   input  wire logic        raw_valid_in,
   input  wire logic        conv_start_in,
   input  wire logic        conv_stop_in,
   // Calibration coefficients
   input  wire logic [23:0] self_offset_coef_in,
   input  wire logic [23:0] self_gain_coef_in,
   input  wire logic [23:0] sys_offset_coef_in,
   input  wire logic [23:0] sys_gain_coef_in,
   // Analog and clock steering, range flags
   output logic             line_frequency_select_out,
   output logic             unipolar_select_out,
   output logic             clock_source_select_out,
   output logic             reference_buffer_enable_out,
   output logic             signal_buffer_enable_out,
   output logic             modulator_run_out,
   output logic             power_down_out,
   output logic             overrange_out,
   output logic             underrange_out
);
   // The byte layout of the pin register fixes the pin count
   if (GPIO_N != 4) begin : g_chk
      $error("GPIO_N must be 4");
   end

   acdr_corr_if c ();

   logic [7:0]  conv_ctl_reg, pin_ctl_reg, cal_ctl_reg;
   logic [17:0] result_reg;
   logic        rdy_reg;
   acdr_conv_t  conv_reg;
   logic [1:0]  disc_reg;
   logic [3:0]  gp_s1_reg, gp_s2_reg;
   logic [7:0]  pin_ctl_view;

   // Link-domain state
   logic        frame_clr;
   logic [5:0]  bit_cnt_reg;
   logic [7:0]  rx_reg, cmd_reg;
   logic [3:0]  wr_rs_reg;
   logic [7:0]  wr_data_reg;
   logic        wr_tog_reg, rd_tog_reg;
   logic [23:0] tx_reg;
   logic        phase_reg;
   logic        req_s1_reg, req_s2_reg, ack_tog_reg;
   logic [41:0] capt_reg;
   logic        cmd_ok, cmd_rd;

   // Core-side crossing state
   logic        wr_s1_reg, wr_s2_reg, wr_s3_reg;
   logic        rd_s1_reg, rd_s2_reg, rd_s3_reg;
   logic        ack_s1_reg, ack_s2_reg;
   logic        req_tog_reg;
   logic [41:0] snap_reg, view;
   logic        wr_evt, rd_evt;

   // Steering outputs and range flags
   assign line_frequency_select_out   = conv_ctl_reg[B_LINE_FREQ];
   assign unipolar_select_out         = conv_ctl_reg[B_UNI];
   assign clock_source_select_out     = conv_ctl_reg[B_CLK_SRC];
   assign reference_buffer_enable_out = conv_ctl_reg[B_REF_BUF];
   assign signal_buffer_enable_out    = conv_ctl_reg[B_SIG_BUF];
   assign modulator_run_out           = conv_reg != CV_OFF;
   assign power_down_out              = conv_reg == CV_OFF;
   assign overrange_out               = c.over;
   assign underrange_out              = c.under;

   // General pins: a pin set as input reads back its synchronised level
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         gp_s1_reg <= 4'h0;
         gp_s2_reg <= 4'h0;
      end else begin
         gp_s1_reg <= gpio_in;
         gp_s2_reg <= gp_s1_reg;
      end
   end

   for (genvar i = 0; i < GPIO_N; i++) begin : g_pin
      assign gpio_out[i]      = pin_ctl_reg[i];
      assign gpio_oe_n_out[i] = ~pin_ctl_reg[B_DIR + i];
      assign pin_ctl_view[i]  = pin_ctl_reg[B_DIR + i] ? pin_ctl_reg[i]
                                                        : gp_s2_reg[i];
      assign pin_ctl_view[B_DIR + i] = pin_ctl_reg[B_DIR + i];
   end

   // Corrector hookup
   assign c.raw       = raw_sample_in;
   assign c.raw_valid = raw_valid_in && conv_reg == CV_RUN;
   assign c.skip      = {cal_ctl_reg[B_SYS_GAIN_OFF], cal_ctl_reg[B_SYS_OFS_OFF],
                         cal_ctl_reg[B_SELF_GAIN_OFF], cal_ctl_reg[B_SELF_OFS_OFF]};
   assign c.gain      = cal_ctl_reg[B_GAIN +: 3];
   assign c.uni       = conv_ctl_reg[B_UNI];
   assign c.fmt       = conv_ctl_reg[B_FORMAT];
   assign c.scoc      = self_offset_coef_in;
   assign c.scgc      = self_gain_coef_in;
   assign c.soc       = sys_offset_coef_in;
   assign c.sgc       = sys_gain_coef_in;

   acdr_corrector u_corr (
      .clk_in   (core_clk_in),
      .rst_n_in (reset_n_in),
      .c        (c.dp)
   );

   // Crossing of link events into the core domain
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_s1_reg <= 1'b0;
         wr_s2_reg <= 1'b0;
         wr_s3_reg <= 1'b0;
         rd_s1_reg <= 1'b0;
         rd_s2_reg <= 1'b0;
         rd_s3_reg <= 1'b0;
      end else begin
         wr_s1_reg <= wr_tog_reg;
         wr_s2_reg <= wr_s1_reg;
         wr_s3_reg <= wr_s2_reg;
         rd_s1_reg <= rd_tog_reg;
         rd_s2_reg <= rd_s1_reg;
         rd_s3_reg <= rd_s2_reg;
      end
   end
   assign wr_evt = wr_s2_reg ^ wr_s3_reg;
   assign rd_evt = rd_s2_reg ^ rd_s3_reg;

   // Register writes; address and data are held steady in the link domain
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         conv_ctl_reg <= CONV_CTL_RST;
         pin_ctl_reg  <= PIN_CTL_RST;
         cal_ctl_reg  <= CAL_CTL_RST;
      end else if (wr_evt) begin
         case (wr_rs_reg)
            RS_CONV_CTL: conv_ctl_reg <= wr_data_reg & CONV_CTL_MASK;
            RS_PIN_CTL:  pin_ctl_reg  <= wr_data_reg;
            RS_CAL_CTL:  cal_ctl_reg  <= wr_data_reg & CAL_CTL_MASK;
            default: ;
         endcase
      end
   end

   // Conversion sequencing; a start outranks a stop in the same cycle
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         conv_reg <= CV_OFF;
         disc_reg <= 2'h0;
      end else if (conv_start_in) begin
         conv_reg <= conv_ctl_reg[B_SINGLE] ? CV_RUN : CV_SETTLE;
         disc_reg <= 2'h0;
      end else if (conv_stop_in) begin
         conv_reg <= CV_OFF;
      end else begin
         case (conv_reg)
            CV_SETTLE: begin
               if (raw_valid_in) begin
                  disc_reg <= disc_reg + 2'h1;
                  if (disc_reg == DISCARD_LAST) conv_reg <= CV_RUN;
               end
            end
            CV_RUN: begin
               if (raw_valid_in && conv_ctl_reg[B_SINGLE]) conv_reg <= CV_OFF;
            end
            default: ;
         endcase
      end
   end

   // Result and ready level; a new result wins over a read clearing ready
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         result_reg <= 18'h0;
         rdy_reg    <= 1'b0;
      end else if (c.code_valid) begin
         result_reg <= c.code;
         rdy_reg    <= 1'b1;
      end else if (rd_evt) begin
         rdy_reg    <= 1'b0;
      end
   end

   // Snapshot for the link; refreshed only after the previous one was taken
   assign view = {conv_ctl_reg, pin_ctl_view, cal_ctl_reg, result_reg};
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ack_s1_reg  <= 1'b0;
         ack_s2_reg  <= 1'b0;
         req_tog_reg <= 1'b0;
         snap_reg    <= 42'h0;
      end else begin
         ack_s1_reg <= ack_tog_reg;
         ack_s2_reg <= ack_s1_reg;
         if (ack_s2_reg == req_tog_reg && snap_reg != view) begin
            snap_reg    <= view;
            req_tog_reg <= ~req_tog_reg;
         end
      end
   end

   // Link domain: frame state is cleared by the frame's own select
   assign frame_clr = chip_select_n_in | ~reset_n_in;
   assign cmd_ok    = cmd_reg[B_START] && cmd_reg[B_MODE];
   assign cmd_rd    = cmd_reg[B_READ];

   always_ff @(posedge sclk_in or posedge frame_clr) begin
      if (frame_clr) begin
         bit_cnt_reg <= 6'h0;
         rx_reg      <= 8'h0;
         cmd_reg     <= 8'h0;
      end else begin
         rx_reg <= {rx_reg[6:0], serial_data_in};
         if (bit_cnt_reg != CNT_MAX) bit_cnt_reg <= bit_cnt_reg + 6'h1;
         if (bit_cnt_reg == CNT_CMD_LAST) cmd_reg <= {rx_reg[6:0], serial_data_in};
      end
   end

   // Write and read-done events survive the frame, so only core reset clears them
   always_ff @(posedge sclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_rs_reg   <= 4'h0;
         wr_data_reg <= 8'h0;
         wr_tog_reg  <= 1'b0;
         rd_tog_reg  <= 1'b0;
      end else if (!chip_select_n_in && cmd_ok) begin
         if (!cmd_rd && bit_cnt_reg == CNT_BYTE_LAST) begin
            wr_rs_reg   <= cmd_reg[B_RS +: 4];
            wr_data_reg <= {rx_reg[6:0], serial_data_in};
            wr_tog_reg  <= ~wr_tog_reg;
         end
         if (cmd_rd && cmd_reg[B_RS +: 4] == RS_DATA && bit_cnt_reg == CNT_WORD_LAST) begin
            rd_tog_reg <= ~rd_tog_reg;
         end
      end
   end

   always_ff @(posedge sclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         req_s1_reg  <= 1'b0;
         req_s2_reg  <= 1'b0;
         ack_tog_reg <= 1'b0;
         capt_reg    <= 42'h0;
      end else begin
         req_s1_reg <= req_tog_reg;
         req_s2_reg <= req_s1_reg;
         if (req_s2_reg != ack_tog_reg) begin
            capt_reg    <= snap_reg;
            ack_tog_reg <= req_s2_reg;
         end
      end
   end

   // Read data leaves on falling edges so the host samples on rising ones
   always_ff @(negedge sclk_in or posedge frame_clr) begin
      if (frame_clr) begin
         tx_reg    <= 24'h0;
         phase_reg <= 1'b0;
      end else if (bit_cnt_reg == CNT_CMD && cmd_ok && cmd_rd && !phase_reg) begin
         phase_reg <= 1'b1;
         case (cmd_reg[B_RS +: 4])
            RS_CONV_CTL: tx_reg <= {capt_reg[41:34], 16'h0};
            RS_PIN_CTL:  tx_reg <= {capt_reg[33:26], 16'h0};
            RS_CAL_CTL:  tx_reg <= {capt_reg[25:18], 16'h0};
            RS_DATA:  tx_reg <= {capt_reg[17:0], 6'h0};
            default:  tx_reg <= 24'h0;
         endcase
      end else if (phase_reg) begin
         tx_reg <= {tx_reg[22:0], 1'b0};
      end
   end

   // Outside a read the pin shows ready; its rise marks end of conversion
   assign rdy_dout_out      = phase_reg ? tx_reg[23] : rdy_reg;
   assign rdy_dout_oe_n_out = chip_select_n_in;

   AST_RDY_RISE:
   assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      c.code_valid |=> rdy_reg && result_reg == $past(c.code))
   else $error("ready not raised with a new result");

   AST_SINGLE_ONE:
   assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      conv_reg == CV_RUN && conv_ctl_reg[B_SINGLE] && raw_valid_in
      && !conv_start_in |=> power_down_out && c.code_valid)
   else $error("single conversion did not power down after one result");

   AST_DISCARD:
   assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      conv_reg == CV_SETTLE |=> !c.code_valid)
   else $error("settling sample reached the result");

   AST_RESULT_RO:
   assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      $changed(result_reg) |-> $past(c.code_valid))
   else $error("result changed without a conversion");

   AST_PIN_DIR:
   assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      wr_evt && wr_rs_reg == RS_PIN_CTL |=> gpio_oe_n_out == ~$past(wr_data_reg[7:4])
      && gpio_out == $past(wr_data_reg[3:0]))
   else $error("pin register write did not steer the pins");

   AST_FRAME_PAD:
   assert property (@(negedge sclk_in) disable iff (frame_clr)
      bit_cnt_reg == CNT_CMD && cmd_ok && cmd_rd && !phase_reg
      && cmd_reg[B_RS +: 4] == RS_DATA |=> phase_reg && tx_reg[5:0] == 6'h0)
   else $error("result frame trailing bits not zero");
endmodule
